/* logic/dic_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dic_defines.svh"

module dic_host #(
    parameter int BUS_CYC = `DIC_BUS_CYC,
    parameter int ACK_CYC = `DIC_ACK_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    dic_link_if.host link,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic irq
);

    if (BUS_CYC < 2 || BUS_CYC > 16 || ACK_CYC < 2 || ACK_CYC > 16) begin : g_bad
        $error("BUS_CYC and ACK_CYC must lie between 2 and 16");
    end

    localparam logic [3:0] BUS_LAST = 4'(BUS_CYC - 1);
    localparam logic [3:0] ACK_LAST = 4'(ACK_CYC - 1);

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = a <= `DIC_A_ACKCTL && a[1:0] == 2'b00;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    logic awHeld_r, wHeld_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r, rdata_r;
    logic [1:0] bresp_r, rresp_r;
    logic [2:0] laddr_r;
    logic [7:0] lwdata_r, lrdata_r, vec_r;
    logic [`DIC_EV_W-1:0] istat_r, imask_r;
    logic autoAck_r, irq_r, irqPrev_r;
    dic_pkg::dic_hstate_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic csN_r, rdN_r, wrN_r, ackN_r, hostOe_r;

    wire awTake = AWVALID && awready_r;
    wire wTake = WVALID && wready_r;
    wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
    wire awHeldNxt = !doWrite && (awHeld_r || awTake);
    wire wHeldNxt = !doWrite && (wHeld_r || wTake);
    wire bvalidNxt = doWrite || (bvalid_r && !BREADY);
    wire arTake = ARVALID && arready_r;
    wire rvalidNxt = arTake || (rvalid_r && !RREADY);
    wire wLow = doWrite && WSTRB[0];
    wire idle = st_r == dic_pkg::H_IDLE;
    // Link commands issued while the link is busy are dropped.
    wire wrStart = idle && wLow && awAddr_r == `DIC_A_LWDATA;
    wire rdStart = idle && wLow && awAddr_r == `DIC_A_LRDCMD;
    // [RULE4] [RULE13]
    wire ackStart = idle && autoAck_r && !link.irqOutN && !wrStart && !rdStart;
    wire finish = !idle && cnt_r == 4'h0;
    wire rdClr = arTake && ARADDR == `DIC_A_ISTAT;
    wire [`DIC_EV_W-1:0] ev;
    wire [31:0] rdMux;

    assign ev[`DIC_EV_REQ] = !link.irqOutN && irqPrev_r;
    assign ev[`DIC_EV_VEC] = finish && st_r == dic_pkg::H_ACK;
    assign ev[`DIC_EV_DONE] = finish && st_r != dic_pkg::H_ACK;

    assign rdMux = ARADDR == `DIC_A_LADDR ? 32'(laddr_r)
        : ARADDR == `DIC_A_LWDATA ? 32'(lwdata_r)
        : ARADDR == `DIC_A_LRDATA ? 32'(lrdata_r)
        : ARADDR == `DIC_A_STATE ? {30'h0, !link.irqOutN, !idle}
        : ARADDR == `DIC_A_VECTOR ? 32'(vec_r)
        : ARADDR == `DIC_A_ISTAT ? 32'(istat_r)
        : ARADDR == `DIC_A_IMASK ? 32'(imask_r)
        : ARADDR == `DIC_A_ACKCTL ? 32'(autoAck_r)
        : 32'h0;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            dic_pkg::H_IDLE: begin
                if (wrStart) begin
                    st_nxt = dic_pkg::H_WRITE;
                    cnt_nxt = BUS_LAST;
                end else if (rdStart) begin
                    st_nxt = dic_pkg::H_READ;
                    cnt_nxt = BUS_LAST;
                end else if (ackStart) begin
                    st_nxt = dic_pkg::H_ACK;
                    cnt_nxt = ACK_LAST;
                end
            end
            dic_pkg::H_WRITE, dic_pkg::H_READ, dic_pkg::H_ACK: begin
                if (cnt_r == 4'h0) begin
                    st_nxt = dic_pkg::H_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default: begin
                st_nxt = dic_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            {awHeld_r, wHeld_r, bvalid_r, rvalid_r} <= 4'h0;
            {awready_r, wready_r, arready_r} <= 3'h0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0;
            rdata_r <= 32'h0;
            bresp_r <= `DIC_RESP_OKAY;
            rresp_r <= `DIC_RESP_OKAY;
        end else begin
            awHeld_r <= awHeldNxt;
            wHeld_r <= wHeldNxt;
            awready_r <= !awHeldNxt && !bvalidNxt;
            wready_r <= !wHeldNxt && !bvalidNxt;
            bvalid_r <= bvalidNxt;
            arready_r <= !rvalidNxt;
            rvalid_r <= rvalidNxt;
            awAddr_r <= awTake ? AWADDR : awAddr_r;
            wData_r <= wTake ? WDATA : wData_r;
            bresp_r <= doWrite ? (isMapped(awAddr_r) ? `DIC_RESP_OKAY
                : `DIC_RESP_SLVERR) : bresp_r;
            rdata_r <= arTake ? rdMux : rdata_r;
            rresp_r <= arTake ? (isMapped(ARADDR) ? `DIC_RESP_OKAY
                : `DIC_RESP_SLVERR) : rresp_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            laddr_r <= 3'h0;
            lwdata_r <= 8'h00;
            imask_r <= '0;
            autoAck_r <= 1'b0;
            istat_r <= '0;
            irq_r <= 1'b0;
            // Starts at the idle level of the request so reset cannot fake a falling edge.
            irqPrev_r <= 1'b1;
        end else begin
            laddr_r <= (wLow && awAddr_r == `DIC_A_LADDR) ? wData_r[2:0] : laddr_r;
            lwdata_r <= wrStart ? wData_r[7:0] : lwdata_r;
            imask_r <= (wLow && awAddr_r == `DIC_A_IMASK)
                ? wData_r[`DIC_EV_W-1:0] : imask_r;
            autoAck_r <= (wLow && awAddr_r == `DIC_A_ACKCTL) ? wData_r[0] : autoAck_r;
            // A read clears the sticky bits; an event in that cycle survives.
            istat_r <= (istat_r & ~(rdClr ? istat_r : '0)) | ev;
            irq_r <= |(istat_r & imask_r);
            irqPrev_r <= link.irqOutN;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_r <= dic_pkg::H_IDLE;
            cnt_r <= 4'h0;
            {csN_r, rdN_r, wrN_r, ackN_r} <= 4'hf;
            hostOe_r <= 1'b0;
            lrdata_r <= 8'h00;
            vec_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            csN_r <= !(st_nxt == dic_pkg::H_WRITE || st_nxt == dic_pkg::H_READ);
            wrN_r <= st_nxt != dic_pkg::H_WRITE;
            rdN_r <= st_nxt != dic_pkg::H_READ;
            ackN_r <= st_nxt != dic_pkg::H_ACK;
            hostOe_r <= st_nxt == dic_pkg::H_WRITE;
            lrdata_r <= (finish && st_r == dic_pkg::H_READ) ? link.dataBus : lrdata_r;
            vec_r <= ev[`DIC_EV_VEC] ? link.dataBus : vec_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign link.csN = csN_r;
    assign link.rdN = rdN_r;
    assign link.wrN = wrN_r;
    assign link.intAckN = ackN_r;
    assign link.addr = laddr_r;
    assign link.hostData = lwdata_r;
    assign link.hostDataOe = hostOe_r;
    assign AWREADY = awready_r;
    assign WREADY = wready_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign ARREADY = arready_r;
    assign RVALID = rvalid_r;
    assign RDATA = rdata_r;
    assign RRESP = rresp_r;
    assign irq = irq_r;

endmodule
`default_nettype wire

/* logic/dic_defines.svh */
// Operation
// [RULE1] Reset leaves the device in direct style.
// [RULE2] Only the enter-chain command selects chained style.
// [RULE3] A needed service drives the request low.
// [RULE4] Chained host answers a request with acknowledge.
// [RULE5] Acknowledge in chained style puts vector on bus.
// [RULE6] Chain enable input counts only in chained style.
// [RULE7] Enable high lets unmasked sources request.
// [RULE8] Masked sources never request.
// [RULE9] Enable low suppresses every request.
// [RULE10] Chained style uses both enables, request, acknowledge.
// [RULE11] Linked enables give upstream devices priority.
// [RULE12] Direct request releases once causes are cleared.
// [RULE13] Direct host clears causes by bus accesses.
// [RULE14] Enable out high only when idle and enabled.
// [RULE15] Enable out stays low until in-service clear.
// [RULE16] Enable out feeds the next device's input.
// [RULE17] Direct style ignores enable input, drives no vector.
`ifndef DIC_DEFINES_SVH
`define DIC_DEFINES_SVH
`define DIC_SRC_N 8
`define DIC_REG_STATUS 3'h0
`define DIC_REG_MASK 3'h1
`define DIC_REG_VECTOR 3'h2
`define DIC_REG_CMD 3'h3
`define DIC_REG_MODE 3'h4
`define DIC_CMD_ENTER_CHAIN 8'h01
`define DIC_CMD_CLEAR_SERVICE 8'h02
`define DIC_CMD_ENTER_DIRECT 8'h03
`define DIC_MASK_RST 8'h00
`define DIC_VECTOR_RST 8'h0f
`define DIC_BUS_CYC 4
`define DIC_ACK_CYC 4
`define DIC_A_LADDR 8'h00
`define DIC_A_LWDATA 8'h04
`define DIC_A_LRDCMD 8'h08
`define DIC_A_LRDATA 8'h0c
`define DIC_A_STATE 8'h10
`define DIC_A_VECTOR 8'h14
`define DIC_A_ISTAT 8'h18
`define DIC_A_IMASK 8'h1c
`define DIC_A_ACKCTL 8'h20
`define DIC_RESP_OKAY 2'b00
`define DIC_RESP_SLVERR 2'b10
`define DIC_EV_REQ 0
`define DIC_EV_VEC 1
`define DIC_EV_DONE 2
`define DIC_EV_W 3
`endif

/* logic/dic_pkg.sv */
package dic_pkg;
    typedef enum logic {
        DIC_DIRECT,
        DIC_CHAINED
    } dic_mode_t;
    typedef enum logic [1:0] {
        H_IDLE,
        H_WRITE,
        H_READ,
        H_ACK
    } dic_hstate_t;
endpackage

/* logic/dic_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface dic_link_if (
    input wire logic core_clk
);
    logic irqOutN;
    logic intAckN;
    logic csN;
    logic rdN;
    logic wrN;
    logic [2:0] addr;
    logic [7:0] hostData;
    logic hostDataOe;
    logic [7:0] devData;
    logic devDataOe;
    logic [7:0] dataBus;

    // The device wins a clash; an undriven bus floats high.
    assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : 8'hff);

    modport dev (
        input intAckN, csN, rdN, wrN, addr, dataBus,
        output irqOutN, devData, devDataOe
    );
    modport host (
        input irqOutN, dataBus,
        output intAckN, csN, rdN, wrN, addr, hostData, hostDataOe
    );
endinterface
`default_nettype wire

/* logic/dic_device.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dic_defines.svh"

module dic_device #(
    parameter int SRC_N = `DIC_SRC_N
) (
    input wire logic core_clk,
    input wire logic rst_b,
    dic_link_if.dev link,
    input wire logic [SRC_N-1:0] irqEvent,
    input wire logic chainEnableIn,
    output logic chainEnableOut,
    output logic chainModeOut,
    output logic inServiceOut
);

    if (SRC_N < 1 || SRC_N > 8) begin : g_bad_src
        $error("SRC_N must lie between 1 and 8");
    end

    ////////////////////////////////////////////////////////////////////////////////

    dic_pkg::dic_mode_t mode_r;
    dic_pkg::dic_mode_t mode_nxt;
    logic [SRC_N-1:0] pend_r;
    logic [SRC_N-1:0] pend_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [7:0] vector_r;
    logic [7:0] vector_nxt;
    logic inService_r;
    logic inService_nxt;
    logic wrPrev_r;
    logic ackPrev_r;
    logic irqOutN_r;
    logic irqOutN_nxt;
    logic chainOut_r;
    logic chainOut_nxt;
    logic vecOe_r;
    logic vecOe_nxt;
    logic devDataOe_r;
    logic devDataOe_nxt;
    logic [7:0] devData_r;
    logic [7:0] devData_nxt;

    ////////////////////////////////////////////////////////////////////////////////

    wire wrNow;
    wire wrTake;
    wire rdNow;
    wire selStatus;
    wire selMask;
    wire selVector;
    wire selCmd;
    wire selMode;
    wire cmdEnterChain;
    wire cmdEnterDirect;
    wire cmdClearService;
    wire chained;
    wire gate;
    wire [SRC_N-1:0] unmasked;
    wire [SRC_N-1:0] clrBits;
    wire reqNow;
    wire ackNow;
    wire ackTake;
    wire [7:0] rdMux;

    assign wrNow = !link.csN && !link.wrN;
    // A write is taken once, at the first edge of its strobe.
    assign wrTake = wrNow && !wrPrev_r;
    assign rdNow = !link.csN && !link.rdN;

    assign selStatus = link.addr == `DIC_REG_STATUS;
    assign selMask = link.addr == `DIC_REG_MASK;
    assign selVector = link.addr == `DIC_REG_VECTOR;
    assign selCmd = link.addr == `DIC_REG_CMD;
    assign selMode = link.addr == `DIC_REG_MODE;

    assign cmdEnterChain = wrTake && selCmd
        && link.dataBus == `DIC_CMD_ENTER_CHAIN;
    assign cmdEnterDirect = wrTake && selCmd
        && link.dataBus == `DIC_CMD_ENTER_DIRECT;
    assign cmdClearService = wrTake && selCmd
        && link.dataBus == `DIC_CMD_CLEAR_SERVICE;

    ////////////////////////////////////////////////////////////////////////////////

    // [RULE2]
    assign mode_nxt = cmdEnterChain ? dic_pkg::DIC_CHAINED
        : (cmdEnterDirect ? dic_pkg::DIC_DIRECT : mode_r);
    assign chained = mode_r == dic_pkg::DIC_CHAINED;

    // [RULE6] [RULE9] [RULE17]
    assign gate = chained ? chainEnableIn : 1'b1;
    // [RULE7] [RULE8]
    assign unmasked = pend_r & mask_r[SRC_N-1:0];
    // [RULE10] [RULE11]
    assign reqNow = (|unmasked) && gate;

    // Causes are cleared by writing ones; a new event in the same cycle wins.
    assign clrBits = (wrTake && selStatus) ? link.dataBus[SRC_N-1:0] : '0;
    // [RULE12] [RULE13]
    assign pend_nxt = (pend_r & ~clrBits) | irqEvent;

    assign mask_nxt = (wrTake && selMask) ? link.dataBus : mask_r;
    assign vector_nxt = (wrTake && selVector) ? link.dataBus : vector_r;

    ////////////////////////////////////////////////////////////////////////////////

    assign ackNow = !link.intAckN;
    // [RULE4] [RULE5] [RULE17]
    assign ackTake = ackNow && !ackPrev_r && chained && reqNow && !inService_r;

    // Leaving chained style also drops service so the chain cannot lock.
    // [RULE15]
    assign inService_nxt = ackTake
        || (inService_r && !cmdClearService && !cmdEnterDirect);

    // [RULE3] [RULE12]
    assign irqOutN_nxt = !(reqNow && !inService_nxt);

    // [RULE14] [RULE15] [RULE16]
    assign chainOut_nxt = chainEnableIn && !reqNow && !inService_nxt;

    // [RULE5]
    assign vecOe_nxt = ackTake || (vecOe_r && ackNow && chained);

    assign rdMux = selStatus ? 8'(pend_r)
        : selMask ? mask_r
        : selVector ? vector_r
        : selMode ? {6'h00, inService_r, chained}
        : 8'h00;

    assign devDataOe_nxt = vecOe_nxt || rdNow;
    assign devData_nxt = vecOe_nxt ? vector_r : rdMux;

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mode_r <= dic_pkg::DIC_DIRECT; // [RULE1]
            pend_r <= '0;
            mask_r <= `DIC_MASK_RST;
            vector_r <= `DIC_VECTOR_RST;
            inService_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            pend_r <= pend_nxt;
            mask_r <= mask_nxt;
            vector_r <= vector_nxt;
            inService_r <= inService_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wrPrev_r <= 1'b0;
            ackPrev_r <= 1'b0;
            irqOutN_r <= 1'b1;
            chainOut_r <= 1'b0;
        end else begin
            wrPrev_r <= wrNow;
            ackPrev_r <= ackNow;
            irqOutN_r <= irqOutN_nxt;
            chainOut_r <= chainOut_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            vecOe_r <= 1'b0;
            devDataOe_r <= 1'b0;
            devData_r <= 8'h00;
        end else begin
            vecOe_r <= vecOe_nxt;
            devDataOe_r <= devDataOe_nxt;
            devData_r <= devData_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign link.irqOutN = irqOutN_r;
    assign link.devData = devData_r;
    assign link.devDataOe = devDataOe_r;
    assign chainEnableOut = chainOut_r;
    assign chainModeOut = mode_r == dic_pkg::DIC_CHAINED;
    assign inServiceOut = inService_r;

endmodule
`default_nettype wire

/* verif/dic_link_checker.sv */
`timescale 1ns/1ns
`default_nettype none

module dic_link_checker #(
    parameter int BUS_CYC = 4,
    parameter int ACK_CYC = 4
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic irqOutN,
    input wire logic intAckN,
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic [2:0] addr,
    input wire logic [7:0] hostData,
    input wire logic hostDataOe,
    input wire logic [7:0] devData,
    input wire logic devDataOe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////////
    // Counters of low cycles, so strobe widths follow the parameters, not a fixed repetition.
    logic [7:0] csCnt_r;
    logic [7:0] csCnt_nxt;
    logic [7:0] ackCnt_r;
    logic [7:0] ackCnt_nxt;
    assign csCnt_nxt = csN ? 8'h00 : csCnt_r + 8'h01;
    assign ackCnt_nxt = intAckN ? 8'h00 : ackCnt_r + 8'h01;
    always_ff @(posedge core_clk) begin
        csCnt_r <= rst_b ? csCnt_nxt : 8'h00;
        ackCnt_r <= rst_b ? ackCnt_nxt : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> irqOutN && intAckN
        && csN && !devDataOe && !hostDataOe) else $error("link not idle after reset");
    a_ack_on_request: assert property ($fell(intAckN) |-> !irqOutN)
        else $error("acknowledge without request");
    a_ack_width: assert property ($rose(intAckN) |-> ackCnt_r == 8'(ACK_CYC))
        else $error("acknowledge width wrong");
    a_vector_drive: assert property ($rose(devDataOe) && !intAckN |-> irqOutN)
        else $error("request not released with vector");
    a_vector_hold: assert property (devDataOe && $past(devDataOe) && !intAckN
        && !$past(intAckN) |-> $stable(devData)) else $error("vector changed");
    a_dev_drive_cause: assert property (devDataOe |-> !$past(intAckN)
        || (!$past(rdN) && !$past(csN))) else $error("device drives bus unasked");
    a_strobe_width: assert property ($rose(csN) |-> csCnt_r == 8'(BUS_CYC))
        else $error("bus strobe width wrong");
    a_one_strobe: assert property (!csN |-> rdN != wrN)
        else $error("read and write strobes together");
    a_addr_stable: assert property (!csN && !$past(csN) |-> $stable(addr))
        else $error("address moved during access");
    a_no_clash: assert property (!(devDataOe && hostDataOe))
        else $error("both ends drive the bus");
    a_ack_apart: assert property (!intAckN |-> csN)
        else $error("acknowledge overlaps bus access");

    c_vector: cover property ($rose(devDataOe) && !intAckN);
    c_write: cover property (!csN && !wrN && hostData == 8'h5a);
    c_read: cover property (!csN && !rdN);
    c_request: cover property ($fell(irqOutN));
endmodule
`default_nettype wire

/* verif/duart_interrupt_daisy_chain_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module duart_interrupt_daisy_chain_tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] AWADDR = 8'h00;
    logic [7:0] ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic AWVALID = 1'b0;
    logic WVALID = 1'b0;
    logic BREADY = 1'b0;
    logic ARVALID = 1'b0;
    logic RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, irq;
    logic [1:0] BRESP, RRESP, r;
    logic [31:0] RDATA, v;
    logic [7:0] irqEvent = 8'h00;
    logic chainEnableIn = 1'b0;
    logic chainEnableOut, chainModeOut, inServiceOut;
    int errors = 0;
    int compares = 0;
    int cyc = 0;

    always #2 core_clk = ~core_clk;

    dic_link_if dic_link_if_inst (.core_clk(core_clk));
    dic_device dic_device_inst (.core_clk(core_clk), .rst_b(rst_b), .link(dic_link_if_inst),
        .irqEvent(irqEvent), .chainEnableIn(chainEnableIn), .chainEnableOut(chainEnableOut),
        .chainModeOut(chainModeOut), .inServiceOut(inServiceOut));
    dic_host dic_host_inst (.core_clk(core_clk), .rst_b(rst_b), .link(dic_link_if_inst),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .irq(irq));
    dic_link_checker dic_link_checker_inst (.core_clk(core_clk), .rst_b(rst_b),
        .irqOutN(dic_link_if_inst.irqOutN), .intAckN(dic_link_if_inst.intAckN),
        .csN(dic_link_if_inst.csN), .rdN(dic_link_if_inst.rdN), .wrN(dic_link_if_inst.wrN),
        .addr(dic_link_if_inst.addr), .hostData(dic_link_if_inst.hostData),
        .hostDataOe(dic_link_if_inst.hostDataOe), .devData(dic_link_if_inst.devData),
        .devDataOe(dic_link_if_inst.devDataOe));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge core_clk);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        r = BRESP;
        BREADY <= 1'b0;
    endtask

    task automatic axiRd(input logic [7:0] a);
        @(posedge core_clk);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge core_clk);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        v = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
    endtask

    // The host drops a link command issued while busy, so every access waits for idle.
    task automatic waitIdle;
        do axiRd(8'h10); while (v[0] !== 1'b0);
    endtask

    task automatic linkWr(input logic [2:0] idx, input logic [7:0] d);
        axiWr(8'h00, {29'h0, idx});
        axiWr(8'h04, {24'h0, d});
        waitIdle();
    endtask

    task automatic linkRd(input logic [2:0] idx);
        axiWr(8'h00, {29'h0, idx});
        axiWr(8'h08, 32'h0);
        waitIdle();
        axiRd(8'h0c);
    endtask

    task automatic pulse(input int b);
        @(posedge core_clk);
        irqEvent[b] <= 1'b1;
        @(posedge core_clk);
        irqEvent[b] <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic reqLow(input logic exp);
        axiRd(8'h10);
        chk("request low", {31'h0, v[1]}, {31'h0, exp});
    endtask

    task conclude;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles; the ceiling leaves wide margin.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        reqLow(1'b0);
        linkRd(3'h4);
        chk("mode", v, 32'h0);
        chk("chain mode", {31'h0, chainModeOut}, 32'h0);
        linkRd(3'h1);
        chk("mask reset", v, 32'h0);
        axiWr(8'h1c, 32'h4);
        linkRd(3'h2);
        chk("vector reset", v, 32'h0f);
        chk("irq raised", {31'h0, irq}, 32'h1);
        axiRd(8'h18);
        chk("istat done", v & 32'h4, 32'h4);
        repeat (2) @(posedge core_clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        axiWr(8'h1c, 32'h0);
        linkRd(3'h4);
        chk("irq masked", {31'h0, irq}, 32'h0);
        pulse(2);
        reqLow(1'b0);
        linkWr(3'h1, 8'h04);
        reqLow(1'b1);
        linkRd(3'h0);
        chk("status", v & 32'h4, 32'h4);
        linkWr(3'h0, 8'h04);
        reqLow(1'b0);
        axiRd(8'h18);
        chk("istat fell", v & 32'h1, 32'h1);
        linkWr(3'h2, 8'h5a);
        linkWr(3'h3, 8'h01);
        linkRd(3'h4);
        chk("mode chained", v & 32'h1, 32'h1);
        chk("chain mode on", {31'h0, chainModeOut}, 32'h1);
        pulse(2);
        pulse(5);
        reqLow(1'b0);
        chk("enable out idle", {31'h0, chainEnableOut}, 32'h0);
        chainEnableIn <= 1'b1;
        reqLow(1'b1);
        chk("enable out busy", {31'h0, chainEnableOut}, 32'h0);
        axiWr(8'h20, 32'h1);
        do axiRd(8'h18); while (v[1] !== 1'b1);
        axiWr(8'h20, 32'h0);
        axiRd(8'h14);
        chk("vector", v, 32'h5a);
        chk("in service", {31'h0, inServiceOut}, 32'h1);
        reqLow(1'b0);
        linkWr(3'h0, 8'h24);
        repeat (3) @(posedge core_clk);
        chk("enable out held", {31'h0, chainEnableOut}, 32'h0);
        linkWr(3'h3, 8'h02);
        repeat (3) @(posedge core_clk);
        chk("enable out free", {31'h0, chainEnableOut}, 32'h1);
        chk("service over", {31'h0, inServiceOut}, 32'h0);
        axiRd(8'h24);
        chk("unmapped read", {r, v[29:0]}, 32'h80000000);
        axiWr(8'h24, 32'h1);
        chk("unmapped write", {30'h0, r}, 32'h2);
        linkWr(3'h3, 8'h03);
        chainEnableIn <= 1'b0;
        pulse(2);
        reqLow(1'b1);
        linkWr(3'h0, 8'h04);
        reqLow(1'b0);
        conclude();
    end
endmodule
`default_nettype wire
